/* core/clcr_pkg.sv */
// Package for the conduction, current limit and loop resistor register bank
package clcr_pkg;

    // ------------------------------------------------------------------
    // Register map (printed offsets are indices, byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [7:0] CLCR_IDX_LIMITS   = 8'h05;
    localparam logic [7:0] CLCR_IDX_LOOP_RES = 8'h06;
    localparam logic [7:0] CLCR_RST_LIMITS   = 8'h00;
    localparam logic [7:0] CLCR_RST_LOOP_RES = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CLCR_FCCM_BIT   = 7;
    localparam int CLCR_REV_BIT    = 6;
    localparam int CLCR_VALLEY_LSB = 3;
    localparam int CLCR_PEAK_LSB   = 0;
    localparam int CLCR_FB_LSB     = 5;
    localparam int CLCR_LOOP_LSB   = 0;

    // ------------------------------------------------------------------
    // Field value mapping
    // ------------------------------------------------------------------
    localparam logic [3:0] CLCR_VALLEY_BASE_A = 4'h1;
    localparam logic [3:0] CLCR_PEAK_BASE_A   = 4'h2;
    localparam logic [8:0] CLCR_FB_BASE_KOHM  = 9'h032;
    localparam logic [8:0] CLCR_FB_STEP_KOHM  = 9'h01e;

    // Loop resistor table in kilohms, entry n is code n
    localparam logic [31:0][11:0] CLCR_LOOP_KOHM = {
        12'd3877, 12'd3753, 12'd3630, 12'd3506,
        12'd3383, 12'd3259, 12'd3136, 12'd3012,
        12'd2889, 12'd2766, 12'd2642, 12'd2519,
        12'd2395, 12'd2272, 12'd2148, 12'd2025,
        12'd1902, 12'd1778, 12'd1655, 12'd1531,
        12'd1408, 12'd1284, 12'd1161, 12'd1038,
        12'd914,  12'd791,  12'd667,  12'd544,
        12'd420,  12'd297,  12'd173,  12'd50
    };

    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] CLCR_RESP_OKAY   = 2'b00;
    localparam logic [1:0] CLCR_RESP_SLVERR = 2'b10;

    // Whole state of the register bank
    typedef struct packed {
        logic        aw_full;
        logic [7:0]  aw_idx;
        logic        w_full;
        logic [7:0]  w_data;
        logic        w_lane0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
        logic [7:0]  limits;
        logic [7:0]  loop_res;
    } clcr_state_t;

endpackage

/* core/clcr_regs.sv */
// AXI4-Lite register bank for conduction mode, current limits, loop resistors
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RULE1 - Bit 7 picks DCM (0) or FCCM (1)
// RULE2 - Valley n+1 amperes, invalid above peak
// RULE3 - Peak code n gives n+2 amperes
// RULE4 - Feedback resistor is 50k plus 30k per code
// RULE5 - Loop resistor from 32-entry table, 50k to 3877k
// RULE6 - Every bit of both registers read/write
// RULE7 - Reads return last write, outputs follow writes
module clcr_regs
    import clcr_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_sys_rst,
    input  wire logic [ADDR_WIDTH-1:0] i_awaddr,
    input  wire logic                  i_awvalid,
    output logic                       o_awready,
    input  wire logic [31:0]           i_wdata,
    input  wire logic [3:0]            i_wstrb,
    input  wire logic                  i_wvalid,
    output logic                       o_wready,
    output logic [1:0]                 o_bresp,
    output logic                       o_bvalid,
    input  wire logic                  i_bready,
    input  wire logic [ADDR_WIDTH-1:0] i_araddr,
    input  wire logic                  i_arvalid,
    output logic                       o_arready,
    output logic [31:0]                o_rdata,
    output logic [1:0]                 o_rresp,
    output logic                       o_rvalid,
    input  wire logic                  i_rready,
    output logic                       o_forced_continuous_select,
    output logic                       o_reverse_limit_bit,
    output logic [2:0]                 o_valley_limit_code,
    output logic [3:0]                 o_valley_limit_amps,
    output logic                       o_valley_limit_valid,
    output logic [2:0]                 o_peak_limit_code,
    output logic [3:0]                 o_peak_limit_amps,
    output logic [2:0]                 o_feedback_resistor_code,
    output logic [8:0]                 o_feedback_resistor_kohm,
    output logic [4:0]                 o_loop_resistor_code,
    output logic [11:0]                o_loop_resistor_kohm
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // The two words sit at byte 0x14 and 0x18, so at least 5 bits are needed
    if (ADDR_WIDTH < 5 || ADDR_WIDTH > 32) begin : g_bad_width
        $error("clcr_regs: ADDR_WIDTH must lie between 5 and 32");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Word index of a byte address; bits above index 255 make it unmapped
    function automatic logic [8:0] word_index(
        input logic [ADDR_WIDTH-1:0] addr
    );
        logic [31:0] wide;
        wide = 32'h0000_0000;
        wide[ADDR_WIDTH-1:0] = addr;
        if (wide[31:10] != 22'h0)
            word_index = 9'h100;
        else
            word_index = {1'b0, wide[9:2]};
    endfunction

    // Map an index onto a one-hot register select, zero when unmapped
    function automatic logic [1:0] reg_select(input logic [8:0] idx);
        reg_select = 2'b00;
        if (idx == {1'b0, CLCR_IDX_LIMITS})
            reg_select = 2'b01;
        else if (idx == {1'b0, CLCR_IDX_LOOP_RES})
            reg_select = 2'b10;
    endfunction

    clcr_state_t state_reg;
    clcr_state_t state_next;

    logic       aw_hs;
    logic       w_hs;
    logic       ar_hs;
    logic       wr_fire;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic       wr_lane0;
    logic [1:0] wr_sel;
    logic [1:0] rd_sel;
    logic [8:0] rd_idx;
    logic [8:0] aw_idx_wide;

    // ------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------
    // Each channel is held until the response drains, one write at a time
    assign o_awready = !state_reg.aw_full && !state_reg.bvalid;
    assign o_wready  = !state_reg.w_full && !state_reg.bvalid;
    assign o_arready = !state_reg.rvalid;
    assign aw_hs     = i_awvalid && o_awready;
    assign w_hs      = i_wvalid && o_wready;
    assign ar_hs     = i_arvalid && o_arready;

    // Held items win over fresh ones; either may come first
    assign aw_idx_wide = word_index(i_awaddr);
    assign wr_idx   = state_reg.aw_full ? state_reg.aw_idx
                    : aw_idx_wide > 9'h0ff ? 8'hff
                    : aw_idx_wide[7:0];
    assign wr_data  = state_reg.w_full ? state_reg.w_data : i_wdata[7:0];
    assign wr_lane0 = state_reg.w_full ? state_reg.w_lane0 : i_wstrb[0];
    assign wr_fire  = (state_reg.aw_full || aw_hs)
                   && (state_reg.w_full || w_hs);
    assign wr_sel   = reg_select({1'b0, wr_idx});
    assign rd_idx   = word_index(i_araddr);
    assign rd_sel   = reg_select(rd_idx);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (aw_hs) begin
            state_next.aw_full = 1'b1;
            state_next.aw_idx  = wr_idx;
        end
        if (w_hs) begin
            state_next.w_full  = 1'b1;
            state_next.w_data  = i_wdata[7:0];
            state_next.w_lane0 = i_wstrb[0];
        end
        // Commit when both halves are in; only byte lane 0 holds data
        if (wr_fire) begin
            state_next.aw_full = 1'b0;
            state_next.w_full  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = (wr_sel != 2'b00) ? CLCR_RESP_OKAY
                                                   : CLCR_RESP_SLVERR;
            if (wr_lane0 && wr_sel[0])
                state_next.limits = wr_data;     // RULE6 RULE7
            if (wr_lane0 && wr_sel[1])
                state_next.loop_res = wr_data;   // RULE6 RULE7
        end
        if (state_reg.bvalid && i_bready)
            state_next.bvalid = 1'b0;
        // Reads answer one cycle after the address is taken
        if (ar_hs) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = (rd_sel != 2'b00) ? CLCR_RESP_OKAY
                                                  : CLCR_RESP_SLVERR;
            case (rd_sel)
                2'b01:   state_next.rdata = state_reg.limits;   // RULE7
                2'b10:   state_next.rdata = state_reg.loop_res; // RULE7
                default: state_next.rdata = 8'h00;
            endcase
        end else if (state_reg.rvalid && i_rready) begin
            state_next.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_reg          <= '0;
            state_reg.limits   <= CLCR_RST_LIMITS;
            state_reg.loop_res <= CLCR_RST_LOOP_RES;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------------
    assign o_bvalid = state_reg.bvalid;
    assign o_bresp  = state_reg.bresp;
    assign o_rvalid = state_reg.rvalid;
    assign o_rresp  = state_reg.rresp;
    assign o_rdata  = {24'h00_0000, state_reg.rdata};

    // ------------------------------------------------------------------
    // Settings to the power stage
    // ------------------------------------------------------------------
    // Fields are slices of the stored bytes, so they move with the write
    assign o_forced_continuous_select =
        state_reg.limits[CLCR_FCCM_BIT];                         // RULE1
    assign o_reverse_limit_bit = state_reg.limits[CLCR_REV_BIT];
    assign o_valley_limit_code =
        state_reg.limits[CLCR_VALLEY_LSB +: 3];
    assign o_peak_limit_code = state_reg.limits[CLCR_PEAK_LSB +: 3];
    assign o_valley_limit_amps =
        {1'b0, o_valley_limit_code} + CLCR_VALLEY_BASE_A;        // RULE2
    assign o_peak_limit_amps =
        {1'b0, o_peak_limit_code} + CLCR_PEAK_BASE_A;            // RULE3
    // A valley setting above the peak is flagged so the stage ignores it
    assign o_valley_limit_valid =
        (o_valley_limit_amps <= o_peak_limit_amps);              // RULE2
    assign o_feedback_resistor_code =
        state_reg.loop_res[CLCR_FB_LSB +: 3];
    assign o_feedback_resistor_kohm = CLCR_FB_BASE_KOHM
        + CLCR_FB_STEP_KOHM * {6'h00, o_feedback_resistor_code}; // RULE4
    assign o_loop_resistor_code = state_reg.loop_res[CLCR_LOOP_LSB +: 5];
    // Steps are not exactly uniform, hence a table rather than arithmetic
    assign o_loop_resistor_kohm =
        CLCR_LOOP_KOHM[o_loop_resistor_code];                    // RULE5

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    property p_mode_follows_write;
        wr_fire && wr_lane0 && wr_sel[0]
            |=> o_forced_continuous_select == $past(wr_data[7]);
    endproperty
    a_mode_follows_write: assert property (p_mode_follows_write) // RULE1
        else $error("conduction mode did not follow bit 7 write");

    property p_valley_map;
        o_valley_limit_valid
            |-> (o_valley_limit_amps == o_valley_limit_code + 4'h1)
             && (o_valley_limit_amps <= o_peak_limit_amps);
    endproperty
    a_valley_map: assert property (p_valley_map) // RULE2
        else $error("valley limit mapping or validity wrong");

    property p_valley_invalid;
        ({1'b0, o_valley_limit_code} > {1'b0, o_peak_limit_code} + 4'h1)
            |-> !o_valley_limit_valid;
    endproperty
    a_valley_invalid: assert property (p_valley_invalid) // RULE2
        else $error("valley above peak still marked valid");

    property p_peak_map;
        o_peak_limit_amps >= 4'h2 && o_peak_limit_amps <= 4'h9
            && o_peak_limit_amps == o_peak_limit_code + 4'h2;
    endproperty
    a_peak_map: assert property (p_peak_map) // RULE3
        else $error("peak limit mapping wrong");

    property p_fb_map;
        o_feedback_resistor_kohm
            == 9'd50 + 9'd30 * {6'h00, o_feedback_resistor_code};
    endproperty
    a_fb_map: assert property (p_fb_map) // RULE4
        else $error("feedback resistor value wrong");

    property p_loop_points;
        (o_loop_resistor_code == 5'h00 |-> o_loop_resistor_kohm == 12'd50)
        and (o_loop_resistor_code == 5'h08
            |-> o_loop_resistor_kohm == 12'd1038);
    endproperty
    a_loop_points: assert property (p_loop_points) // RULE5
        else $error("loop resistor table point wrong");

    property p_loop_hold;
        !wr_fire |=> $stable(o_loop_resistor_kohm)
            && $stable(state_reg.loop_res);
    endproperty
    a_loop_hold: assert property (p_loop_hold) // RULE6
        else $error("loop resistor register changed without a write");

    property p_limits_hold;
        !wr_fire |=> $stable(state_reg.limits);
    endproperty
    a_limits_hold: assert property (p_limits_hold) // RULE6
        else $error("limit register changed without a write");

    // A write that lands must carry the written byte, every bit of it
    property p_loop_lands;
        wr_fire && wr_lane0 && wr_sel[1]
            |=> state_reg.loop_res == $past(wr_data);
    endproperty
    a_loop_lands: assert property (p_loop_lands) // RULE6
        else $error("loop resistor register did not take the write");

    property p_limits_lands;
        wr_fire && wr_lane0 && wr_sel[0]
            |=> state_reg.limits == $past(wr_data);
    endproperty
    a_limits_lands: assert property (p_limits_lands) // RULE7
        else $error("limit register did not take the write");

    // Refused or masked writes still answer but must not store
    property p_refused_keeps;
        wr_fire && !(wr_lane0 && wr_sel != 2'b00)
            |=> $stable(state_reg.limits) && $stable(state_reg.loop_res)
             && o_bvalid;
    endproperty
    a_refused_keeps: assert property (p_refused_keeps) // RULE7
        else $error("refused write changed a register");

    property p_read_back;
        ar_hs && rd_sel == 2'b10 ##1 1'b1
            |-> o_rvalid && o_rdata[7:0] == $past(state_reg.loop_res)
             && o_rdata[31:8] == 24'h00_0000;
    endproperty
    a_read_back: assert property (p_read_back) // RULE7
        else $error("read of loop resistor register returned wrong data");

endmodule

`default_nettype wire

/* sim/test_clcr_regs.sv */
// Self-checking bench for the conduction, limit and loop resistor registers
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    err_total++; $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end end
module test_clcr_regs import clcr_pkg::*;;
    // ------------------------------------------------------------------
    // Signals and constants
    // ------------------------------------------------------------------
    localparam logic [7:0] A_LIM  = {CLCR_IDX_LIMITS[5:0], 2'b00};
    localparam logic [7:0] A_LOOP = {CLCR_IDX_LOOP_RES[5:0], 2'b00};
    localparam logic [31:0] R_LIM  = {24'h00_0000, CLCR_RST_LIMITS};
    localparam logic [31:0] R_LOOP = {24'h00_0000, CLCR_RST_LOOP_RES};
    logic        i_clock, i_sys_rst, i_awvalid, i_wvalid, i_bready;
    logic        i_arvalid, i_rready;
    logic [7:0]  i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0]  i_wstrb;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;
    logic        o_fccm, o_rev, o_vvalid;
    logic [2:0]  o_vcode, o_pcode, o_fbcode;
    logic [3:0]  o_vamps, o_pamps;
    logic [8:0]  o_fbkohm;
    logic [4:0]  o_lcode;
    logic [11:0] o_lkohm;
    int          err_total = 0;
    int          compares = 0;
    // Resistance per loop code, independent of the design's table
    int rc_tab [32] = '{50, 173, 297, 420, 544, 667, 791, 914, 1038, 1161,
        1284, 1408, 1531, 1655, 1778, 1902, 2025, 2148, 2272, 2395, 2519,
        2642, 2766, 2889, 3012, 3136, 3259, 3383, 3506, 3630, 3753, 3877};

    clcr_regs dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_forced_continuous_select(o_fccm), .o_reverse_limit_bit(o_rev),
        .o_valley_limit_code(o_vcode), .o_valley_limit_amps(o_vamps),
        .o_valley_limit_valid(o_vvalid), .o_peak_limit_code(o_pcode),
        .o_peak_limit_amps(o_pamps), .o_feedback_resistor_code(o_fbcode),
        .o_feedback_resistor_kohm(o_fbkohm), .o_loop_resistor_code(o_lcode),
        .o_loop_resistor_kohm(o_lkohm));

    // ------------------------------------------------------------------
    // Clock, verdict and watchdog
    // ------------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic complete_run();
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Both passes need about 2100 cycles, so 20000 means a hang
    initial begin
        repeat (20000) @(posedge i_clock);
        err_total++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Bus tasks: readies sampled at the falling edge, where they are settled
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] exp_resp);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] resp;
        i_awaddr  <= a;
        i_wdata   <= d;
        i_wstrb   <= s;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        do begin
            @(negedge i_clock);
            aw_hs = i_awvalid && o_awready;
            w_hs = i_wvalid && o_wready;
            b_hs = o_bvalid;
            resp = o_bresp;
            @(posedge i_clock);
            if (aw_hs) i_awvalid <= 1'b0;
            if (w_hs) i_wvalid <= 1'b0;
        end while (!b_hs);
        `CHECK("bresp", exp_resp, resp)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp_d,
                          input logic [1:0] exp_resp);
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0] resp;
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        do begin
            @(negedge i_clock);
            ar_hs = i_arvalid && o_arready;
            r_hs = o_rvalid;
            d = o_rdata;
            resp = o_rresp;
            @(posedge i_clock);
            if (ar_hs) i_arvalid <= 1'b0;
        end while (!r_hs);
        `CHECK("rdata", exp_d, d)
        `CHECK("rresp", exp_resp, resp)
    endtask

    // Every setting output against the value held in each register
    task automatic chk_out(input logic [7:0] lim, input logic [7:0] lr);
        logic vv;
        // Valley is valid unless its amperes exceed the peak amperes
        vv = ({1'b0, lim[5:3]} + 4'h1) <= ({1'b0, lim[2:0]} + 4'h2);
        `CHECK("fccm", lim[7], o_fccm)
        `CHECK("rev", lim[6], o_rev)
        `CHECK("vcode", lim[5:3], o_vcode)
        `CHECK("vamps", {1'b0, lim[5:3]} + 4'h1, o_vamps)
        `CHECK("vvalid", vv, o_vvalid)
        `CHECK("pcode", lim[2:0], o_pcode)
        `CHECK("pamps", {1'b0, lim[2:0]} + 4'h2, o_pamps)
        `CHECK("fbcode", lr[7:5], o_fbcode)
        `CHECK("fbkohm", 9'h032 + 9'h01e * {6'h00, lr[7:5]}, o_fbkohm)
        `CHECK("lcode", lr[4:0], o_lcode)
        `CHECK("lkohm", rc_tab[lr[4:0]], o_lkohm)
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] wl, wn;
        i_sys_rst <= 1'b1;
        {i_awvalid, i_wvalid, i_arvalid, i_bready, i_rready} <= 5'h00;
        {i_awaddr, i_araddr, i_wstrb} <= 20'h0_0000;
        i_wdata <= 32'h0000_0000;
        for (int pass = 0; pass < 2; pass++) begin
            i_sys_rst <= 1'b1;
            repeat (2) @(posedge i_clock);
            i_sys_rst <= 1'b0;
            i_bready  <= 1'b1;
            i_rready  <= 1'b1;
            repeat (2) @(posedge i_clock);
            // Reset values, also after a reset in mid-run
            rd_chk(A_LIM, R_LIM, CLCR_RESP_OKAY);
            rd_chk(A_LOOP, R_LOOP, CLCR_RESP_OKAY);
            chk_out(CLCR_RST_LIMITS, CLCR_RST_LOOP_RES);
            if (pass == 0) begin
                // Every code of both registers, back to back
                for (int i = 0; i < 256; i++) begin
                    wl = {24'h00_0000, i[7:0]};
                    wn = {24'h00_0000, ~i[7:0]};
                    wr(A_LIM, wl, 4'h1, CLCR_RESP_OKAY);
                    wr(A_LOOP, wn, 4'h1, CLCR_RESP_OKAY);
                    chk_out(wl[7:0], wn[7:0]);
                    rd_chk(A_LIM, wl, CLCR_RESP_OKAY);
                    rd_chk(A_LOOP, wn, CLCR_RESP_OKAY);
                end
                // Refused and partial writes leave the stored value alone
                wr(A_LIM, 32'h0000_00a5, 4'h1, CLCR_RESP_OKAY);
                wr(8'h1c, 32'h0000_00ff, 4'h1, CLCR_RESP_SLVERR);
                wr(8'h00, 32'h0000_00ff, 4'h1, CLCR_RESP_SLVERR);
                wr(A_LIM, 32'h0000_00ff, 4'he, CLCR_RESP_OKAY);
                rd_chk(A_LIM, 32'h0000_00a5, CLCR_RESP_OKAY);
                rd_chk(8'h1c, 32'h0000_0000, CLCR_RESP_SLVERR);
                // Low address bits and upper data bits are ignored
                wl = 32'hffff_ff3c;
                wr(A_LIM | 8'h03, wl, 4'h1, CLCR_RESP_OKAY);
                rd_chk(A_LIM, 32'h0000_003c, CLCR_RESP_OKAY);
                chk_out(8'h3c, 8'h00);
            end
        end
        complete_run();
    end
endmodule
`undef CHECK
`default_nettype wire
